// >>> logic/mrtu_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "mrtu_consts.svh"
// How it works
// RL1 - checksum covers only the eight data bits
// RL2 - remainder over the sixteen-bit generator polynomial
// RL3 - feedback constant is reflected a001 hex
// RL4 - accumulator preset to ffff each packet
// RL5 - byte XORed into low accumulator byte
// RL6 - eight right shifts with conditional feedback
// RL7 - value after last byte is result
// RL8 - response checksum sent low byte first
// RL9 - accept packet only on zero remainder
// RL10 - supported codes 03, 04, 05, 06, 10; 05, 06 and 10 are accepted without any action or reply
// RL11 - codes 03 and 04 behave identically
// RL12 - read asks one to 125 registers
// RL13 - register words go high byte first
// RL14 - request: address, code, start, count, checksum
// RL15 - reply: address, code, byte count, words, checksum
// RL16 - words fetched ascending through read port
// RL17 - bad register count gets exception reply
// RL18 - packet ends after 3.5 idle characters
// RL19 - bad checksum: no action, no reply
// RL20 - broadcast only with 05, never answered
// RL21 - exception: code top bit, error byte
module mrtu_slave #(
  parameter int unsigned IDLE_CYCLES = `MRTU_IDLE_CYCLES,
  parameter int unsigned FIFO_DEPTH  = 8
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // configuration
  input  wire logic [7:0]  slave_addr,
  // received bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  packet_byte_in,
  // transmitted bytes
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        tx_ready,
  // register read port
  output logic             rd_en,
  output logic [15:0]      rd_addr,
  input  wire logic [15:0] rd_data,
  // status
  output logic             busy
);
  localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);

  mrtu_pkg::mrtu_state_t state;
  mrtu_pkg::mrtu_state_t next_state;
  logic [7:0]  hdr [`MRTU_HDR_BYTES];
  logic [3:0]  rx_cnt;
  logic [IW-1:0] idle_cnt;
  logic        resp_exc;
  logic [7:0]  exc_code;
  logic [6:0]  remain;
  logic [15:0] word;
  logic [7:0]  push_byte;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;

  mrtu_crc_if crc_bus ();

  // packet decode
  wire [15:0] qty       = {hdr[4], hdr[5]};
  wire [7:0]  fc        = hdr[1];
  wire        crc_ok    = crc_bus.value == `MRTU_CRC_GOOD; // RL9
  wire        is_bcast  = hdr[0] == `MRTU_BCAST_ADDR;
  wire        addr_ok   = hdr[0] == slave_addr; // RL20
  wire        is_read   = fc == `MRTU_FC_RD_HOLD || fc == `MRTU_FC_RD_INPUT; // RL11
  wire        supported = is_read || fc == `MRTU_FC_EXEC || fc == `MRTU_FC_STORE_ONE
                          || fc == `MRTU_FC_STORE_MANY; // RL10
  wire        qty_ok    = qty != 16'h0000 && qty <= `MRTU_MAX_REGS; // RL12
  wire        rd_shape  = is_read && rx_cnt == `MRTU_RD_REQ_LEN; // RL14
  // dead time: rx_valid in the same cycle extends the packet instead
  wire        frame_end = state == mrtu_pkg::ST_RX && !rx_valid && rx_cnt != 4'h0
                          && idle_cnt == IW'(IDLE_CYCLES - 1); // RL18
  wire        accept    = frame_end && crc_ok && addr_ok && rx_cnt >= `MRTU_MIN_LEN; // RL9 RL19
  wire        go_read   = accept && rd_shape && qty_ok;
  wire        go_exc    = accept && (!supported || (rd_shape && !qty_ok)); // RL17 RL21
  wire        push_st   = state inside {mrtu_pkg::ST_ADDR, mrtu_pkg::ST_FUNC,
                          mrtu_pkg::ST_BCNT, mrtu_pkg::ST_HI, mrtu_pkg::ST_LO,
                          mrtu_pkg::ST_EXC, mrtu_pkg::ST_CRCL, mrtu_pkg::ST_CRCH};
  wire        push      = push_st && fifo_in_ready;
  wire        crc_st    = state == mrtu_pkg::ST_CRCL || state == mrtu_pkg::ST_CRCH;
  wire        fifo_take = !tx_valid || tx_ready;

  // the checksum engine is shared: the link is half duplex
  assign crc_bus.init = (state == mrtu_pkg::ST_RX && rx_valid && rx_cnt == 4'h0)
                        || go_read || go_exc; // RL4
  assign crc_bus.en   = (state == mrtu_pkg::ST_RX && rx_valid) || (push && !crc_st); // RL1
  assign crc_bus.data = state == mrtu_pkg::ST_RX ? packet_byte_in : push_byte;

  always_comb begin
    case (state)
      mrtu_pkg::ST_ADDR: push_byte = hdr[0]; // RL15
      mrtu_pkg::ST_FUNC: push_byte = resp_exc ? (fc | `MRTU_EXC_FLAG) : fc; // RL21
      mrtu_pkg::ST_BCNT: push_byte = {hdr[5][6:0], 1'b0}; // RL15
      mrtu_pkg::ST_HI:   push_byte = word[15:8]; // RL13
      mrtu_pkg::ST_LO:   push_byte = word[7:0]; // RL13
      mrtu_pkg::ST_EXC:  push_byte = exc_code; // RL21
      mrtu_pkg::ST_CRCL: push_byte = crc_bus.value[7:0]; // RL8
      mrtu_pkg::ST_CRCH: push_byte = crc_bus.value[15:8]; // RL8
      default:           push_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      mrtu_pkg::ST_RX: begin
        if (go_read || go_exc) next_state = mrtu_pkg::ST_ADDR;
      end
      mrtu_pkg::ST_ADDR: begin
        if (push) next_state = mrtu_pkg::ST_FUNC;
      end
      mrtu_pkg::ST_FUNC: begin
        if (push) next_state = resp_exc ? mrtu_pkg::ST_EXC : mrtu_pkg::ST_BCNT;
      end
      mrtu_pkg::ST_BCNT: begin
        if (push) next_state = mrtu_pkg::ST_FETCH;
      end
      mrtu_pkg::ST_FETCH: next_state = mrtu_pkg::ST_WAIT;
      mrtu_pkg::ST_WAIT:  next_state = mrtu_pkg::ST_HI;
      mrtu_pkg::ST_HI: begin
        if (push) next_state = mrtu_pkg::ST_LO;
      end
      mrtu_pkg::ST_LO: begin
        if (push) next_state = remain == 7'h00 ? mrtu_pkg::ST_CRCL : mrtu_pkg::ST_FETCH; // RL7
      end
      mrtu_pkg::ST_EXC: begin
        if (push) next_state = mrtu_pkg::ST_CRCL;
      end
      mrtu_pkg::ST_CRCL: begin
        if (push) next_state = mrtu_pkg::ST_CRCH; // RL8
      end
      mrtu_pkg::ST_CRCH: begin
        if (push) next_state = mrtu_pkg::ST_RX;
      end
      default: next_state = mrtu_pkg::ST_RX;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= mrtu_pkg::ST_RX;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= next_state != mrtu_pkg::ST_RX;
    end
  end

  // receive side; bytes arriving while answering are dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt   <= 4'h0;
      idle_cnt <= '0;
      for (int b = 0; b < `MRTU_HDR_BYTES; b++) hdr[b] <= 8'h00;
    end else if (state != mrtu_pkg::ST_RX || frame_end) begin
      rx_cnt   <= 4'h0;
      idle_cnt <= '0;
    end else if (rx_valid) begin
      if (rx_cnt < 4'(`MRTU_HDR_BYTES)) hdr[rx_cnt[2:0]] <= packet_byte_in; // RL14
      if (rx_cnt != 4'hf) rx_cnt <= rx_cnt + 4'h1;
      idle_cnt <= '0;
    end else if (rx_cnt != 4'h0) begin
      idle_cnt <= idle_cnt + 1'b1; // RL18
    end
  end

  // response bookkeeping and register fetch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp_exc <= 1'b0;
      exc_code <= 8'h00;
      remain   <= 7'h00;
      rd_addr  <= 16'h0000;
      rd_en    <= 1'b0;
      word     <= 16'h0000;
    end else begin
      rd_en <= state == mrtu_pkg::ST_FETCH; // RL16
      if (go_read || go_exc) begin
        resp_exc <= go_exc;
        exc_code <= supported ? `MRTU_EXC_BAD_VALUE : `MRTU_EXC_BAD_FUNC; // RL17 RL21
        remain   <= qty[6:0];
        rd_addr  <= {hdr[2], hdr[3]};
      end
      if (state == mrtu_pkg::ST_FETCH) remain <= remain - 7'h01;
      if (state == mrtu_pkg::ST_WAIT) begin
        word    <= rd_data; // RL16
        rd_addr <= rd_addr + 16'h0001; // RL16
      end
    end
  end

  mrtu_crc u_crc (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .crc     (crc_bus.engine)
  );

  // the fifo decouples the byte builder from a slow serialiser
  mrtu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push_st),
    .in_ready  (fifo_in_ready),
    .in_data   (push_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out_data)
  );

  // output stage keeps tx pins registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
    end else if (fifo_take) begin
      tx_valid <= fifo_out_valid;
      if (fifo_out_valid) tx_byte <= fifo_out_data;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_bad_frame;
    frame_end && !crc_ok;
  endsequence
  sequence s_silent;
    state == mrtu_pkg::ST_RX [*2];
  endsequence

  property p_bad_crc;
    s_bad_frame |=> s_silent;
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("reply to bad checksum"); // RL19

  property p_bcast;
    frame_end && is_bcast |=> s_silent;
  endproperty
  a_bcast: assert property (p_bcast) else $error("reply to broadcast"); // RL20

  property p_unsup;
    frame_end && crc_ok && addr_ok && !supported && rx_cnt >= `MRTU_MIN_LEN
      |=> state == mrtu_pkg::ST_ADDR && resp_exc && exc_code == 8'h01;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported code not refused"); // RL10

  property p_exc_func;
    state == mrtu_pkg::ST_FUNC && push && resp_exc |-> push_byte[7];
  endproperty
  a_exc_func: assert property (p_exc_func) else $error("exception flag missing"); // RL21

  property p_qty;
    frame_end && crc_ok && addr_ok && rd_shape && (qty == 16'h0000 || qty > 16'h007d)
      |=> resp_exc;
  endproperty
  a_qty: assert property (p_qty) else $error("bad count not refused"); // RL17

  property p_bcnt;
    state == mrtu_pkg::ST_BCNT && push |-> push_byte == 8'(qty * 2);
  endproperty
  a_bcnt: assert property (p_bcnt) else $error("wrong byte count"); // RL15

  property p_word_order;
    state == mrtu_pkg::ST_HI && push
      |=> state == mrtu_pkg::ST_LO && push_byte == $past(word[7:0]);
  endproperty
  a_word_order: assert property (p_word_order) else $error("word byte order"); // RL13

  property p_crc_order;
    state == mrtu_pkg::ST_CRCL && push
      |=> state == mrtu_pkg::ST_CRCH && push_byte == $past(crc_bus.value[15:8]);
  endproperty
  a_crc_order: assert property (p_crc_order) else $error("checksum byte order"); // RL8

  property p_fetch;
    state == mrtu_pkg::ST_FETCH |=> rd_en ##1 rd_addr == $past(rd_addr) + 16'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address not ascending"); // RL16

  property p_read_go;
    frame_end && crc_ok && addr_ok && rd_shape && qty_ok
      |=> state == mrtu_pkg::ST_ADDR && !resp_exc;
  endproperty
  a_read_go: assert property (p_read_go) else $error("read not started"); // RL11

  property p_addr_echo;
    state == mrtu_pkg::ST_ADDR && push |-> push_byte == slave_addr;
  endproperty
  a_addr_echo: assert property (p_addr_echo) else $error("reply address differs"); // RL15

  // a read of the wrong length is dropped rather than refused
  property p_len;
    frame_end && crc_ok && addr_ok && is_read && rx_cnt != `MRTU_RD_REQ_LEN
      |=> s_silent;
  endproperty
  a_len: assert property (p_len) else $error("odd-length read answered"); // RL14
endmodule
`default_nettype wire

// >>> logic/mrtu_consts.svh
`ifndef MRTU_CONSTS_SVH
`define MRTU_CONSTS_SVH

// checksum
`define MRTU_CRC_PRESET     16'hffff
`define MRTU_CRC_POLY       16'ha001
`define MRTU_CRC_GOOD       16'h0000

// packet fields
`define MRTU_BCAST_ADDR     8'h00
`define MRTU_FC_RD_HOLD     8'h03
`define MRTU_FC_RD_INPUT    8'h04
`define MRTU_FC_EXEC        8'h05
`define MRTU_FC_STORE_ONE   8'h06
`define MRTU_FC_STORE_MANY  8'h10
`define MRTU_EXC_FLAG       8'h80
`define MRTU_EXC_BAD_FUNC   8'h01
`define MRTU_EXC_BAD_VALUE  8'h03
`define MRTU_MAX_REGS       16'h007d
`define MRTU_RD_REQ_LEN     4'h8
`define MRTU_MIN_LEN        4'h4
`define MRTU_HDR_BYTES      6

// timing
`define MRTU_CLK_PERIOD_NS  10
`define MRTU_CHAR_TIME_NS   520834
`define MRTU_DEAD_HALF_CHARS 7
`define MRTU_IDLE_CYCLES \
  ((`MRTU_CHAR_TIME_NS * `MRTU_DEAD_HALF_CHARS / 2 + `MRTU_CLK_PERIOD_NS - 1) \
   / `MRTU_CLK_PERIOD_NS)

`endif

// >>> logic/mrtu_pkg.sv
`default_nettype none
package mrtu_pkg;
  typedef enum logic [3:0] {
    ST_RX, ST_ADDR, ST_FUNC, ST_BCNT, ST_FETCH, ST_WAIT,
    ST_HI, ST_LO, ST_EXC, ST_CRCL, ST_CRCH
  } mrtu_state_t;
endpackage
`default_nettype wire

// >>> logic/mrtu_crc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mrtu_crc_if;
  logic        init;
  logic        en;
  logic [7:0]  data;
  logic [15:0] value;
  modport user   (output init, output en, output data, input value);
  modport engine (input init, input en, input data, output value);
endinterface
`default_nettype wire

// >>> logic/mrtu_crc.sv
`timescale 1ns/10ps
`default_nettype none
`include "mrtu_consts.svh"
module mrtu_crc (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // byte stream
  mrtu_crc_if.engine crc
);
  logic [15:0] acc;
  logic [15:0] base;
  logic [15:0] stepped;

  // only data bits ever reach here, the serial framing is stripped upstream
  function automatic logic [15:0] crc_step(input logic [15:0] a, input logic [7:0] d);
    logic [15:0] r;
    r = a ^ {8'h00, d}; // RL5
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `MRTU_CRC_POLY) : (r >> 1); // RL2 RL3 RL6
    end
    return r;
  endfunction

  assign base    = crc.init ? `MRTU_CRC_PRESET : acc; // RL4
  assign stepped = crc_step(base, crc.data); // RL1
  assign crc.value = acc; // RL7

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc <= `MRTU_CRC_PRESET;
    end else if (crc.en) begin
      acc <= stepped;
    end else if (crc.init) begin
      acc <= `MRTU_CRC_PRESET;
    end
  end

  property p_preset;
    @(posedge clk_sys) disable iff (!rst_n)
      crc.init && !crc.en |=> acc == `MRTU_CRC_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("crc not preset"); // RL4

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !crc.init && !crc.en |=> $stable(acc);
  endproperty
  a_hold: assert property (p_hold) else $error("crc moved without a byte"); // RL7
endmodule
`default_nettype wire

// >>> logic/mrtu_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module mrtu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              wr_go = in_valid && !full;
  wire              rd_go = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mem[e] <= '0;
        end else if (wr_go && wr_ptr[AW-1:0] == AW'(e)) begin
          mem[e] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (wr_go) wr_ptr <= wr_ptr + 1'b1;
      if (rd_go) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/mrtu_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module mrtu_far_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // pacing from the bench
  input  wire logic        slow,
  // serialiser side
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_byte,
  output logic             tx_ready,
  // register store side
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic [15:0]      rd_data
);
  byte unsigned got[$];
  logic [15:0]  word;

  assign word = (rd_addr * 16'h9e37) ^ 16'h1234;
  // idle store shows the inverse so a sample taken off the strobe cannot match
  assign rd_data = rd_en ? word : ~word;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else begin
      // stalls fill the fifo and hold the builder back
      tx_ready <= slow ? ($urandom_range(2, 0) != 0) : 1'b1;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_byte);
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int IDLE = 20;
  logic        clk_sys;
  logic        rst_n;
  logic        rx_valid;
  logic [7:0]  packet_byte_in;
  logic        slow;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic        tx_ready;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic [15:0] rd_data;
  logic        busy;
  int          n_fail;
  int          checks;
  byte unsigned q[$];
  byte unsigned e[$];
  logic [15:0] st;
  logic [7:0]  sa;

  mrtu_slave #(.IDLE_CYCLES(IDLE), .FIFO_DEPTH(8)) mrtu_slave_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .slave_addr(sa), .rx_valid(rx_valid),
    .packet_byte_in(packet_byte_in), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .busy(busy));

  mrtu_far_model mrtu_far_model_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] crc16(input byte unsigned b[$]);
    int a;
    a = 'hffff;
    foreach (b[i]) begin
      a = a ^ b[i];
      for (int j = 0; j < 8; j++) begin
        a = (a & 1) ? ((a >> 1) ^ 'ha001) : (a >> 1);
      end
    end
    return a[15:0];
  endfunction

  function automatic logic [15:0] wd(input logic [15:0] a);
    logic [15:0] p;
    p = a * 16'h9e37;
    return p ^ 16'h1234;
  endfunction

  task automatic close_out();
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // sends a request with its checksum and compares the whole reply
  task automatic xfer(input byte unsigned req[$], input bit bad, input bit gap,
                      input byte unsigned exp[$]);
    logic [15:0] c;
    int n;
    bit hb;
    c = crc16(req) ^ {15'h0, bad};
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    if (exp.size() > 0) begin
      c = crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    mrtu_far_model_inst.got.delete();
    foreach (req[i]) begin
      if (gap && i == 4) begin
        // a pause just under the dead time must not split the packet
        @(posedge clk_sys);
        #1 rx_valid = 1'b0;
        repeat (IDLE - 4) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      #1 rx_valid = 1'b1;
      packet_byte_in = req[i];
    end
    @(posedge clk_sys);
    #1 rx_valid = 1'b0;
    packet_byte_in = $urandom();
    hb = 1'b0;
    repeat (IDLE + 40) begin
      @(negedge clk_sys);
      if (busy === 1'b1) hb = 1'b1;
    end
    cmp(hb, exp.size() > 0);
    n = 0;
    while (mrtu_far_model_inst.got.size() < exp.size() && n < 8000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 8000) begin
      n_fail++;
      $display("[FAIL] %0t reply never completed", $time);
      close_out();
    end
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp(mrtu_far_model_inst.got.size(), exp.size());
    foreach (exp[i]) begin
      if (i < mrtu_far_model_inst.got.size()) begin
        cmp(mrtu_far_model_inst.got[i], exp[i]);
      end
    end
    cmp(busy, 1'b0);
  endtask

  // read request and the reply expected from the word store
  task automatic rd(input logic [7:0] fc, input logic [15:0] s, input logic [15:0] cnt,
                    input bit gap);
    byte unsigned x[$];
    logic [15:0] w;
    x = {sa, fc, s[15:8], s[7:0], cnt[15:8], cnt[7:0]};
    e = {sa, fc, 8'(cnt * 2)};
    for (int k = 0; k < cnt; k++) begin
      w = wd(s + 16'(k));
      e.push_back(w[15:8]);
      e.push_back(w[7:0]);
    end
    xfer(x, 1'b0, gap, e);
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    rst_n = 1'b0;
    rx_valid = 1'b0;
    packet_byte_in = 8'h00;
    slow = 1'b0;
    sa = 8'h11;
    void'($urandom(32));
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    q = {8'h11, 8'h04, 8'h40, 8'h50, 8'h00, 8'h03};
    cmp(crc16(q), 16'h4aa7);
    q = {8'h11, 8'h04, 8'h06, 8'h00, 8'h28, 8'h01, 8'h2c, 8'h00, 8'h00};
    cmp(crc16(q), 16'h600d);
    q = {8'h11, 8'h39, 8'hcd, 8'hf2};
    cmp(crc16(q), 16'h0000);
    for (int f = 3; f <= 4; f++) begin
      for (int m = 0; m < 3; m++) begin
        st = $urandom_range(16'hff00, 0);
        slow = m[0];
        rd(8'(f), st, m == 0 ? 16'h0001 : (m == 1 ? 16'h0003 : 16'h007d), 1'b0);
      end
    end
    slow = 1'b1;
    rd(8'h03, 16'h4050, 16'h0003, 1'b1);
    slow = 1'b0;
    for (int m = 0; m < 2; m++) begin
      q = {8'h11, 8'h03, 8'h00, 8'h10, 8'h00, (m == 0 ? 8'h00 : 8'h7e)};
      e = {8'h11, 8'h83, 8'h03};
      xfer(q, 1'b0, 1'b0, e);
    end
    for (int m = 0; m < 2; m++) begin
      q = {8'h11, (m == 0 ? 8'h01 : 8'h39)};
      e = {8'h11, (m == 0 ? 8'h81 : 8'hb9), 8'h01};
      xfer(q, 1'b0, 1'b0, e);
    end
    for (int m = 0; m < 3; m++) begin
      q = {8'h11, (m == 0 ? 8'h05 : (m == 1 ? 8'h06 : 8'h10)), 8'h00, 8'h01, 8'hff, 8'h00};
      e = {};
      xfer(q, 1'b0, 1'b0, e);
    end
    q = {8'h11, 8'h03, 8'h40, 8'h50, 8'h00, 8'h02};
    xfer(q, 1'b1, 1'b0, e);
    q[0] = 8'h00;
    xfer(q, 1'b0, 1'b0, e);
    q = {8'h00, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00};
    xfer(q, 1'b0, 1'b0, e);
    q = {8'h12, 8'h03, 8'h40, 8'h50, 8'h00, 8'h02};
    xfer(q, 1'b0, 1'b0, e);
    q = {8'h11, 8'h03, 8'h40, 8'h50};
    xfer(q, 1'b0, 1'b0, e);
    @(posedge clk_sys);
    #1 sa = 8'($urandom_range(254, 1));
    rd(8'h04, 16'hfff0, 16'h0002, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
